// file: tmch_params.svh
// Constants for the serial line-card bus transceiver-side controller.
`ifndef TMCH_PARAMS_SVH
`define TMCH_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TMCH_REG_CTRL 4'h0
`define TMCH_REG_STATUS 4'h4
`define TMCH_REG_MON_TX 4'h8
`define TMCH_REG_MON_RX 4'hc

// ----------------------------------------------------------------------------
// Frame layout and handshake levels
// ----------------------------------------------------------------------------
`define TMCH_HS_ACT 1'b0
`define TMCH_HS_INACT 1'b1
`define TMCH_IDLE_BYTE 8'hff
`define TMCH_D_IDLE 2'h3
`define TMCH_SLOT_MON 2'h2
`define TMCH_SLOT_CTL 2'h3
`define TMCH_BIT_LAST 3'h7
`define TMCH_CTL_TXHS 0
`define TMCH_CTL_RXHS 1
`define TMCH_CTL_CI 5:2
`define TMCH_SF 7:5
`define TMCH_SLOT 4:3
`define TMCH_BIT 2:0
`define TMCH_BC_ONE 8'h01
`define TMCH_TMO_FRAMES 8'hc8
`define TMCH_TMO_ONE 8'h01

// ----------------------------------------------------------------------------
// Upstream indication codes sent by this end
// ----------------------------------------------------------------------------
`define TMCH_UP_TIMING_REQUIRED 4'h0
`define TMCH_UP_RESET_CODE 4'h1
`define TMCH_UP_RESYNC_INDICATION 4'h4
`define TMCH_UP_U_ONLY_ACT_INDICATION 4'h7
`define TMCH_UP_ACT_REQUEST 4'h8
`define TMCH_UP_ACT_INDICATION 4'hc
`define TMCH_UP_DEACT_INDICATION 4'hf

// ----------------------------------------------------------------------------
// Downstream command codes received from the handler
// ----------------------------------------------------------------------------
`define TMCH_DN_DEACT_REQUEST 4'h0
`define TMCH_DN_RESET_CODE 4'h1
`define TMCH_DN_TEST_MODE_TWO 4'h2
`define TMCH_DN_TEST_MODE_ONE 4'h3
`define TMCH_DN_U_ONLY_ACT_REQUEST 4'h7
`define TMCH_DN_ACT_REQUEST 4'h8
`define TMCH_DN_ACT_REQ_LOOP_TWO 4'h9
`define TMCH_DN_ACT_REQ_LOCAL_LOOP 4'ha
`define TMCH_DN_ACT_REQ_LOOP_FOUR 4'hb
`define TMCH_DN_ACT_INDICATION 4'hc
`define TMCH_DN_DEACT_CONFIRM 4'hf

`endif

// file: tmch_pkg.sv
// Types and reset values of the transceiver-side controller.
`include "tmch_params.svh"
package tmch_pkg;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_FIRST = 5'h02, TX_NEXT = 5'h04, TX_HOLD = 5'h08, TX_END = 5'h10
  } tmch_tx_st_t;

  typedef enum logic [5:0] {
    RX_IDLE = 6'h01, RX_WAIT = 6'h02, RX_ACKLO = 6'h04, RX_ACK = 6'h08, RX_NEWB = 6'h10,
    RX_ABORT = 6'h20
  } tmch_rx_st_t;

  typedef struct packed {
    logic [18:0] pad;
    logic rx_abort;
    logic [3:0] ci;
    logic [2:0] pad2;
    logic coll;
    logic dll;
    logic [2:0] sf;
  } tmch_ctrl_t;

  typedef struct packed {
    logic [18:0] pad;
    logic rx_busy;
    logic rx_end;
    logic rx_avail;
    logic tx_busy;
    logic need_pair;
    logic tmo;
    logic abort;
    logic done;
    logic ci_chg;
    logic [3:0] ci_acc;
  } tmch_status_t;

  typedef struct packed {
    logic [14:0] pad;
    logic last;
    logic [15:0] pair;
  } tmch_montx_t;

  typedef struct packed {
    logic [22:0] pad;
    logic avail;
    logic [7:0] data;
  } tmch_monrx_t;

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
  } tmch_sync_t;

  typedef struct packed {
    tmch_rx_st_t st;
    logic first;
    logic txhs_p;
    logic [7:0] cand;
    logic [7:0] data;
    logic vld;
    logic msg_end;
    logic rxhs;
  } tmch_rx_t;

  typedef struct packed {
    logic dcl_p;
    logic [7:0] bc;
    logic [7:0] sh;
    logic [7:0] rx_mon;
    logic up_bit;
    logic up_oe;
    tmch_tx_st_t tx_st;
    logic [7:0] tx_byte;
    logic txhs;
    logic hi;
    logic acked;
    logic end_cnt;
    logic [7:0] tmo_cnt;
    logic rxhs_act_p;
    logic [15:0] pair;
    logic last;
    logic pend;
    logic [3:0] ci_prev;
    logic [3:0] ci_acc;
    logic ci_chg;
    logic done_f;
    logic abort_f;
    logic tmo_f;
    logic [7:0] rx_data;
    logic avail;
    logic rx_end_f;
    tmch_ctrl_t ctrl;
    logic wait_q;
    logic [31:0] rdata;
  } tmch_main_t;

  localparam tmch_rx_t TMCH_RX_RST = '{st: RX_IDLE, rxhs: `TMCH_HS_INACT, default: '0};
  localparam tmch_main_t TMCH_MAIN_RST = '{tx_st: TX_IDLE, tx_byte: `TMCH_IDLE_BYTE,
    txhs: `TMCH_HS_INACT, up_bit: 1'b1, wait_q: 1'b1, ctrl: '0, default: '0};

endpackage

// file: tmch_sync.sv
// Two-flop synchroniser for the link pins.
`timescale 1ns/1ns
`default_nettype none
module tmch_sync
  import tmch_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Pins in and synchronised copies out
  input wire logic [2:0] async_i,
  output logic [2:0] sync_o
);
  tmch_sync_t q, d;

  always_comb begin
    d = q;
    d.meta = async_i;
    d.sync = q.meta;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.sync;
endmodule // tmch_sync
`default_nettype wire

// file: tmch_mon_rx.sv
// Monitor receiver: acknowledges downstream monitor bytes of one subframe.
`timescale 1ns/1ns
`default_nettype none
module tmch_mon_rx
  import tmch_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Frame results
  input wire logic frm_i,
  input wire logic txhs_i,
  input wire logic [7:0] byte_i,
  // Control
  input wire logic dll_en_i,
  input wire logic ready_i,
  input wire logic abort_i,
  // Results
  output logic rxhs_o,
  output logic [7:0] byte_o,
  output logic vld_o,
  output logic msg_end_o,
  output logic busy_o
);
  tmch_rx_t q, d;
  logic txhs_act;

  always_comb begin
    d = q;
    d.vld = 1'b0;
    d.msg_end = 1'b0;
    txhs_act = txhs_i == `TMCH_HS_ACT;
    if (frm_i) begin
      d.txhs_p = txhs_act;
      d.cand = byte_i;
      case (q.st)
        RX_IDLE: begin
          if (txhs_act) begin
            d.st = RX_WAIT;
            d.first = 1'b1;
          end
        end
        RX_WAIT: begin
          if (!txhs_act && !q.txhs_p) begin
            d.st = RX_IDLE;
            d.msg_end = 1'b1;
          end else if (txhs_act && ready_i && (!dll_en_i || byte_i == q.cand)) begin
            d.data = byte_i;
            d.vld = 1'b1;
            d.st = q.first ? RX_ACK : RX_ACKLO;
          end
        end
        RX_ACKLO: d.st = RX_ACK;
        RX_ACK: begin
          if (!txhs_act) begin
            d.st = RX_NEWB;
          end
        end
        RX_NEWB: begin
          if (!txhs_act) begin
            d.st = RX_IDLE;
            d.msg_end = 1'b1;
          end else begin
            d.st = RX_WAIT;
            d.first = 1'b0;
          end
        end
        RX_ABORT: begin
          if (!txhs_act && !q.txhs_p) begin
            d.st = RX_IDLE;
          end
        end
        default: d.st = RX_IDLE;
      endcase
    end
    // Abort keeps the acknowledge bit inactive until the sender gives up.
    if (abort_i && q.st != RX_IDLE) begin
      d.st = RX_ABORT;
    end
    // While software has not taken the last byte, holding the bit active stalls the sender of any byte after the first.
    d.rxhs = (d.st == RX_ACK || d.st == RX_NEWB || (d.st == RX_WAIT && !d.first)) ? `TMCH_HS_ACT
           : `TMCH_HS_INACT;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= TMCH_RX_RST;
    end else begin
      q <= d;
    end
  end

  assign rxhs_o = q.rxhs;
  assign byte_o = q.data;
  assign vld_o = q.vld;
  assign msg_end_o = q.msg_end;
  assign busy_o = q.st != RX_IDLE;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_first_ack_inact: assert property (frm_i && q.st == RX_IDLE && txhs_act |=> rxhs_o == `TMCH_HS_INACT)
    else $error("first byte seen with acknowledge bit active");
  a_ack_pulse: assert property (frm_i && q.st == RX_ACKLO |-> rxhs_o == `TMCH_HS_INACT ##1 rxhs_o == `TMCH_HS_ACT)
    else $error("acknowledge pulse not exactly one frame");
  a_msg_end_rx: assert property (frm_i && q.st == RX_NEWB && !txhs_act |=> msg_end_o && !busy_o)
    else $error("end of message not ending reception");
endmodule // tmch_mon_rx
`default_nettype wire

// file: tmch_host.sv
// Transceiver-side controller for the monitor and command/indicate channels of one subframe.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module tmch_host
  import tmch_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Serial bus pins
  input wire logic bit_clk_i,
  input wire logic frame_sync_i,
  input wire logic downstream_line_i,
  output logic upstream_line_o,
  output logic upstream_line_oe_o,
  output logic collision_report_in_o
);
  tmch_main_t q, d;
  logic [2:0] syn;
  logic dcl_s, fsc_s, dn_s;
  logic rise, fall, mine, frm, mon_end, rxhs_act, ack, hit, rd_rx, rx_abort;
  logic [7:0] rx_byte, ctl_byte, bc_n;
  logic [31:0] rdata;
  logic rx_hs, rx_vld, rx_end, rx_busy;
  logic [7:0] rx_data;
  tmch_status_t st_rd, clr;
  tmch_montx_t mtx;
  tmch_ctrl_t cw;

  function automatic logic hs_act(input logic b);
    return b == `TMCH_HS_ACT;
  endfunction

  function automatic logic ser(input logic [7:0] v, input logic [2:0] idx);
    return v[`TMCH_BIT_LAST - idx];
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchroniser and monitor receiver
  // --------------------------------------------------------------------------
  tmch_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i({bit_clk_i, frame_sync_i, downstream_line_i}),
    .sync_o(syn)
  );

  assign {dcl_s, fsc_s, dn_s} = syn;

  tmch_mon_rx u_mon_rx (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .frm_i(frm),
    .txhs_i(rx_byte[`TMCH_CTL_TXHS]),
    .byte_i(q.rx_mon),
    .dll_en_i(q.ctrl.dll),
    .ready_i(!q.avail),
    .abort_i(rx_abort),
    .rxhs_o(rx_hs),
    .byte_o(rx_data),
    .vld_o(rx_vld),
    .msg_end_o(rx_end),
    .busy_o(rx_busy)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    d = q;
    rise = dcl_s && !q.dcl_p;
    fall = !dcl_s && q.dcl_p;
    mine = q.bc[`TMCH_SF] == q.ctrl.sf;
    rx_byte = {q.sh[6:0], dn_s};
    mon_end = fall && mine && q.bc[`TMCH_SLOT] == `TMCH_SLOT_MON && q.bc[`TMCH_BIT] == `TMCH_BIT_LAST;
    frm = fall && mine && q.bc[`TMCH_SLOT] == `TMCH_SLOT_CTL && q.bc[`TMCH_BIT] == `TMCH_BIT_LAST;
    rxhs_act = hs_act(rx_byte[`TMCH_CTL_RXHS]);
    ack = frm && rxhs_act && !q.rxhs_act_p;
    hit = (avs_read_i || avs_write_i) && !q.wait_q;
    rd_rx = hit && avs_read_i && avs_address_i == `TMCH_REG_MON_RX;
    cw = tmch_ctrl_t'(avs_writedata_i);
    clr = tmch_status_t'(avs_writedata_i);
    mtx = tmch_montx_t'(avs_writedata_i);
    rx_abort = hit && avs_write_i && avs_address_i == `TMCH_REG_CTRL && cw.rx_abort;
    ctl_byte = {`TMCH_D_IDLE, q.ctrl.ci, rx_hs, q.txhs};
    bc_n = fsc_s ? '0 : q.bc + `TMCH_BC_ONE;

    st_rd = '0;
    st_rd.rx_busy = rx_busy;
    st_rd.rx_end = q.rx_end_f;
    st_rd.rx_avail = q.avail;
    st_rd.tx_busy = q.tx_st != TX_IDLE;
    st_rd.need_pair = !q.pend;
    st_rd.tmo = q.tmo_f;
    st_rd.abort = q.abort_f;
    st_rd.done = q.done_f;
    st_rd.ci_chg = q.ci_chg;
    st_rd.ci_acc = q.ci_acc;
    case (avs_address_i)
      `TMCH_REG_CTRL: rdata = q.ctrl;
      `TMCH_REG_STATUS: rdata = st_rd;
      `TMCH_REG_MON_TX: rdata = {15'h0000, q.last, q.pair};
      `TMCH_REG_MON_RX: rdata = {23'h000000, q.avail, q.rx_data};
      default: rdata = '0;
    endcase

    // ------------------------------------------------------------------------
    // Register bus: answer one cycle after the request, act on the next edge.
    // ------------------------------------------------------------------------
    d.wait_q = 1'b1;
    if ((avs_read_i || avs_write_i) && q.wait_q) begin
      d.wait_q = 1'b0;
      d.rdata = rdata;
    end
    if (hit && avs_write_i) begin
      case (avs_address_i)
        `TMCH_REG_CTRL: begin
          d.ctrl = cw;
          d.ctrl.rx_abort = 1'b0;
          d.ctrl.pad = '0;
          d.ctrl.pad2 = '0;
        end
        `TMCH_REG_STATUS: begin
          d.ci_chg = q.ci_chg && !clr.ci_chg;
          d.done_f = q.done_f && !clr.done;
          d.abort_f = q.abort_f && !clr.abort;
          d.tmo_f = q.tmo_f && !clr.tmo;
          d.rx_end_f = q.rx_end_f && !clr.rx_end;
        end
        `TMCH_REG_MON_TX: begin
          // Bytes come in pairs, so an odd-length message cannot be expressed.
          if (!q.pend) begin
            d.pair = mtx.pair;
            d.last = mtx.last;
            d.pend = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (rd_rx) begin
      d.avail = 1'b0;
    end
    // Hardware events below override the software clears above.
    if (rx_vld) begin
      d.rx_data = rx_data;
      d.avail = 1'b1;
    end
    if (rx_end) begin
      d.rx_end_f = 1'b1;
    end

    // ------------------------------------------------------------------------
    // Serial timing: drive on the clock rise, sample on the fall.
    // ------------------------------------------------------------------------
    d.dcl_p = dcl_s;
    if (fall) begin
      d.sh = rx_byte;
    end
    if (mon_end) begin
      d.rx_mon = rx_byte;
    end
    if (rise) begin
      d.bc = bc_n;
      d.up_oe = bc_n[`TMCH_SF] == q.ctrl.sf;
      d.up_bit = 1'b1;
      if (bc_n[`TMCH_SF] == q.ctrl.sf) begin
        case (bc_n[`TMCH_SLOT])
          `TMCH_SLOT_MON: d.up_bit = ser(q.tx_byte, bc_n[`TMCH_BIT]);
          `TMCH_SLOT_CTL: d.up_bit = ser(ctl_byte, bc_n[`TMCH_BIT]);
          default: d.up_bit = 1'b1;
        endcase
      end
    end

    // ------------------------------------------------------------------------
    // Per-frame handling at the end of the control slot
    // ------------------------------------------------------------------------
    if (frm) begin
      d.rxhs_act_p = rxhs_act;
      d.ci_prev = rx_byte[`TMCH_CTL_CI];
      if (rx_byte[`TMCH_CTL_CI] == q.ci_prev && rx_byte[`TMCH_CTL_CI] != q.ci_acc) begin
        d.ci_acc = rx_byte[`TMCH_CTL_CI];
        d.ci_chg = 1'b1;
      end
      d.tmo_cnt = q.tmo_cnt + `TMCH_TMO_ONE;
      case (q.tx_st)
        TX_IDLE: begin
          d.tmo_cnt = '0;
          if (q.pend) begin
            d.tx_byte = q.pair[7:0];
            d.hi = 1'b0;
            d.acked = 1'b0;
            d.pend = 1'b0;
            d.txhs = `TMCH_HS_ACT;
            d.tx_st = TX_FIRST;
          end
        end
        TX_FIRST, TX_HOLD: begin
          if (ack && !q.hi) begin
            d.tmo_cnt = '0;
            d.tx_byte = q.pair[15:8];
            d.hi = 1'b1;
            d.txhs = `TMCH_HS_INACT;
            d.tx_st = TX_NEXT;
          end else if (ack && q.last) begin
            d.tx_byte = `TMCH_IDLE_BYTE;
            d.txhs = `TMCH_HS_INACT;
            d.end_cnt = 1'b0;
            d.done_f = 1'b1;
            d.tx_st = TX_END;
          end else if (ack) begin
            d.tmo_cnt = '0;
            d.acked = 1'b1;
          end else if (q.acked && q.pend && !rxhs_act) begin
            d.tmo_cnt = '0;
            d.tx_byte = q.pair[7:0];
            d.hi = 1'b0;
            d.acked = 1'b0;
            d.pend = 1'b0;
            d.txhs = `TMCH_HS_INACT;
            d.tx_st = TX_NEXT;
          end else if (q.tx_st == TX_HOLD && !q.acked && !rxhs_act && !q.rxhs_act_p) begin
            d.abort_f = 1'b1;
            d.tx_byte = `TMCH_IDLE_BYTE;
            d.txhs = `TMCH_HS_INACT;
            d.end_cnt = 1'b0;
            d.tx_st = TX_END;
          end else if (q.tmo_cnt == `TMCH_TMO_FRAMES) begin
            d.tmo_f = 1'b1;
            d.tx_byte = `TMCH_IDLE_BYTE;
            d.txhs = `TMCH_HS_INACT;
            d.end_cnt = 1'b0;
            d.tx_st = TX_END;
          end
        end
        TX_NEXT: begin
          d.txhs = `TMCH_HS_ACT;
          d.tx_st = TX_HOLD;
        end
        TX_END: begin
          // The inactive bit and idle byte stay for two frames here and one more in TX_IDLE before a new start.
          if (q.end_cnt) begin
            d.tx_st = TX_IDLE;
          end else begin
            d.end_cnt = 1'b1;
          end
        end
        default: d.tx_st = TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= TMCH_MAIN_RST;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.wait_q;
  assign upstream_line_o = q.up_bit;
  assign upstream_line_oe_o = q.up_oe;
  assign collision_report_in_o = q.ctrl.coll;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_end_data_ones: assert property (frm && q.tx_st == TX_END |-> q.tx_byte == `TMCH_IDLE_BYTE && q.txhs)
    else $error("end of message without idle data");
  a_next_one_frame: assert property (frm && q.tx_st == TX_NEXT |=> q.tx_st == TX_HOLD && !q.txhs)
    else $error("next byte frame not followed by active bit");
  a_first_held: assert property (frm && q.tx_st == TX_FIRST && !ack && q.tmo_cnt != `TMCH_TMO_FRAMES
    |=> q.tx_st == TX_FIRST && $stable(q.tx_byte) && !q.txhs)
    else $error("first byte changed before acknowledge");
  a_abort_seen: assert property (frm && q.tx_st == TX_HOLD && !q.acked && !ack && !rxhs_act && !q.rxhs_act_p
    |=> q.abort_f && q.tx_st == TX_END)
    else $error("receiver abort not recognised");
  a_stall_hold: assert property (frm && q.tx_st == TX_HOLD && rxhs_act && q.rxhs_act_p && !q.acked
    && q.tmo_cnt != `TMCH_TMO_FRAMES |=> q.tx_st == TX_HOLD)
    else $error("transmitter moved on while receiver stalled");
  a_ci_double: assert property (frm && rx_byte[`TMCH_CTL_CI] != q.ci_prev |=> $stable(q.ci_acc))
    else $error("code accepted after a single frame");
  a_idle_line_ones: assert property (!upstream_line_oe_o |-> upstream_line_o)
    else $error("line not idle outside own subframe");
  a_bus_wait_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");

  c_tx_done: cover property ($rose(q.done_f));
  c_tx_abort: cover property ($rose(q.abort_f));
  c_rx_end: cover property (rx_end);
  c_ci_change: cover property ($rose(q.ci_chg));
endmodule // tmch_host
`default_nettype wire

// file: tmch_dev_model.sv
// Behavioural line-card handler facing the controller on the serial bus.
`timescale 1ns/1ns
`default_nettype none
module tmch_dev_model #(
  parameter int SF = 3
) (
  // Core clock and controller pins
  input wire logic clk_i,
  input wire logic up_i,
  input wire logic oe_i,
  output logic bclk_o,
  output logic fsync_o,
  output logic dn_o
);
  logic [2:0] c = 3'h0;
  logic [7:0] b = 8'h0;
  logic [7:0] db = 8'hff;
  logic [3:0] dci = 4'h0;
  logic [31:0] up = '1;
  logic [31:0] uw = '1;
  logic dmx = 1, dmr = 1, busy = 0, snd = 0, no_ack = 0, umx_p = 1, umr_p = 1, nw, ack;
  logic [7:0] q_up[$], q_dn[$];
  int bad = 0;
  event fe;
  // Data moves one core clock before the bit clock rises, so it is settled at both edges.
  wire logic [31:0] sw = {16'hffff, db, 2'h3, dci, dmr, dmx};
  assign bclk_o = c inside {[3'h2:3'h5]};
  assign fsync_o = b == 8'h0;
  assign dn_o = b[7:5] == SF ? sw[~b[4:0]] : 1'b1;
  always @(posedge clk_i) begin
    c <= c + 3'h1;
    if (c == 3'h0) begin
      b <= b + 8'h1;
      if (b[7:5] == SF) begin
        up = {up[30:0], up_i};
        bad += !oe_i;
      end else begin
        bad += oe_i;
      end
      if (b == 8'hff) begin
        bad += up[31:16] != 16'hffff || up[7:6] != 2'h3;
        if (umx_p && up[0]) busy = 0;
        nw = umx_p && !up[0];
        if (nw) q_up.push_back(up[15:8]);
        dmr = (no_ack && busy) || !(busy ^ nw);
        busy = busy || nw;
        ack = umr_p && !up[1];
        if (!snd && q_dn.size() > 0) begin
          snd = 1;
          dmx = 0;
          db = q_dn[0];
        end else if (snd && dmx) begin
          dmx = 0;
        end else if (snd && ack) begin
          void'(q_dn.pop_front());
          dmx = 1;
          snd = q_dn.size() > 0;
          db = snd ? q_dn[0] : 8'hff;
        end
        umx_p = up[0];
        umr_p = up[1];
        uw = up;
        -> fe;
      end
    end
  end
endmodule // tmch_dev_model
`default_nettype wire

// file: tb_tdm_monitor_ci_handler.sv
// Self-checking bench for the controller against the handler model.
`timescale 1ns/1ns
`default_nettype none
module tb_tdm_monitor_ci_handler;
  logic core_clk_i = 0, rst_i = 1, rd = 0, wr = 0, wreq, up, oe, coll, bclk, fs, dn;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [7:0] b0, b1, r0, r1;
  logic [7:0] rxq[$];
  int n_errors = 0, total_checks = 0;
  localparam logic [3:0] up_c[7] = '{4'h0, 4'h1, 4'h4, 4'h7, 4'h8, 4'hc, 4'hf};
  localparam logic [3:0] dn_c[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hf};
  tmch_host i_tmch_host (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .bit_clk_i(bclk), .frame_sync_i(fs), .downstream_line_i(dn),
    .upstream_line_o(up), .upstream_line_oe_o(oe), .collision_report_in_o(coll));
  tmch_dev_model #(.SF(3)) i_tmch_dev_model (.clk_i(core_clk_i), .up_i(up), .oe_i(oe),
    .bclk_o(bclk), .fsync_o(fs), .dn_o(dn));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge core_clk_i); while (wreq !== 1'h0);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  // Each frame the receive register is polled, so a held byte never stalls the link for long.
  task automatic fr(input int n);
    repeat (n) begin
      @(i_tmch_dev_model.fe);
      bus(1'h0, 4'hc, 32'h0);
      if (q[8]) rxq.push_back(q[7:0]);
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial forever #20 core_clk_i = ~core_clk_i;
  initial begin
    #(40 * 2048 * 40);
    n_errors++;
    stop_test;
  end
  initial begin
    void'($urandom(32'h5e32));
    {r1, r0, b1, b0} = $urandom();
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'h0;
    chk("collision", 0, coll);
    bus(1'h0, 4'h0, 32'h0);
    chk("ctrl", 0, q);
    bus(1'h0, 4'h2, 32'h0);
    chk("unmapped", 0, q);
    bus(1'h0, 4'h4, 32'h0);
    chk("need_pair", 1, q[8]);
    i_tmch_dev_model.q_dn = '{r0, r1};
    bus(1'h1, 4'h8, {15'h0, 1'h1, b1, b0});
    for (int i = 0; i < 11; i++) begin
      i_tmch_dev_model.dci = dn_c[i];
      bus(1'h1, 4'h0, {20'h0, up_c[i % 7], 3'h0, i[0], 4'hb});
      if (i == 1) i_tmch_dev_model.bad = 0;
      fr(2);
      bus(1'h0, 4'h4, 32'h0);
      chk("ci accepted", dn_c[i], q[3:0]);
      chk("ci sent", up_c[i % 7], i_tmch_dev_model.uw[5:2]);
      chk("collision", i[0], coll);
    end
    chk("tx count", 2, i_tmch_dev_model.q_up.size());
    chk("tx bytes", {b0, b1}, {i_tmch_dev_model.q_up[0], i_tmch_dev_model.q_up[1]});
    chk("tx idle", 9'h1ff, {i_tmch_dev_model.uw[15:8], i_tmch_dev_model.uw[0]});
    chk("rx bytes", {r0, r1}, {rxq[0], rxq[1]});
    chk("tx done", 1, q[5]);
    chk("rx eom", 1, q[11]);
    bus(1'h1, 4'h4, 32'h10);
    i_tmch_dev_model.no_ack = 1;
    bus(1'h1, 4'h8, {16'h1, 16'($urandom())});
    @(i_tmch_dev_model.fe);
    i_tmch_dev_model.dci = 4'h6;
    fr(1);
    i_tmch_dev_model.dci = 4'hf;
    fr(8);
    bus(1'h0, 4'h4, 32'h0);
    chk("ci glitch", 4'hf, q[3:0]);
    chk("ci glitch change", 0, q[4]);
    chk("abort", 1, q[6]);
    chk("frame layout", 0, i_tmch_dev_model.bad);
    stop_test;
  end
endmodule // tb_tdm_monitor_ci_handler
`default_nettype wire
